// ===== rtl/tsb_host.sv
// Purpose: Host that drives enable, clock direction and master-side bus pins.
// Assumes: The buffer sits between this master and the far segment.
// Notes: Bus clock comes from a divider and never waits on the slave.
`timescale 1ns/1ps
module tsb_host #(
  parameter int unsigned STARTUP_CYC = tsb_pkg::STARTUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en_req,
  input wire logic dir_req,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_ack,
  input wire logic [7:0] cmd_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack,
  output logic bus_idle,
  output logic bus_en,
  output logic clk_dir,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);

  tsb_pkg::tsb_state_t state_q;
  logic [1:0] s1_q, s2_q, s3_q, f_q;
  logic [tsb_pkg::CNT_W-1:0] cnt_q;
  logic [1:0] q_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic read_q, stop_q, ack_q, open_q;
  logic sda_pull_q, scl_pull_q;
  logic rsp_valid_q, rsp_nack_q;
  logic [7:0] rsp_rdata_q;
  logic [31:0] start_cnt_q;
  logic done_q, en_q, dir_q;
  logic tick, take;

  // Bit 1 is the clock pin, bit 0 the data pin.
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= tsb_pkg::PINS_RST;
      s2_q <= tsb_pkg::PINS_RST;
      s3_q <= tsb_pkg::PINS_RST;
    end else begin
      s1_q <= {scl_i, sda_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      always_ff @(posedge clk) begin
        if (rst) begin
          f_q[gi] <= 1'b1;
        end else if (s2_q[gi] == s3_q[gi]) begin
          f_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst || state_q == tsb_pkg::TSB_IDLE || tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick = (state_q != tsb_pkg::TSB_IDLE) &&
                (cnt_q == tsb_pkg::QUARTER_LAST);
  assign bus_idle = (state_q == tsb_pkg::TSB_IDLE) && !open_q &&
                    (f_q == tsb_pkg::PINS_RST);
  assign cmd_ready = (state_q == tsb_pkg::TSB_IDLE) && en_q && !dir_q &&
                     done_q;
  assign take = cmd_valid && cmd_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      start_cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      start_cnt_q <= start_cnt_q + 32'h1;
      done_q <= (start_cnt_q == 32'(STARTUP_CYC - 1));
    end
  end

  // Enable and direction move only while the bus is idle.
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= 1'b0;
      dir_q <= 1'b0;
    end else if (bus_idle) begin
      en_q <= en_req && done_q;
      dir_q <= dir_req;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= tsb_pkg::TSB_IDLE;
      q_q <= 2'h0;
      bit_q <= tsb_pkg::BIT_FIRST;
      shift_q <= 8'h00;
      read_q <= 1'b0;
      stop_q <= 1'b0;
      ack_q <= 1'b0;
      open_q <= 1'b0;
      sda_pull_q <= 1'b0;
      scl_pull_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_nack_q <= 1'b0;
      rsp_rdata_q <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      if (tick) begin
        q_q <= q_q + 2'h1;
      end
      case (state_q)
        tsb_pkg::TSB_IDLE: begin
          if (take) begin
            read_q <= cmd_read;
            stop_q <= cmd_stop;
            ack_q <= cmd_ack;
            shift_q <= cmd_read ? 8'hff : cmd_wdata;
            bit_q <= tsb_pkg::BIT_FIRST;
            q_q <= 2'h0;
            if (cmd_start || !open_q) begin
              state_q <= tsb_pkg::TSB_START;
              sda_pull_q <= 1'b0;
            end else begin
              state_q <= tsb_pkg::TSB_BIT;
              sda_pull_q <= !cmd_read && !cmd_wdata[7];
            end
          end
        end
        tsb_pkg::TSB_START: begin
          if (tick) begin
            case (q_q)
              2'h0: scl_pull_q <= 1'b0;
              2'h2: sda_pull_q <= 1'b1;
              2'h3: begin
                scl_pull_q <= 1'b1;
                open_q <= 1'b1;
                sda_pull_q <= !shift_q[7];
                state_q <= tsb_pkg::TSB_BIT;
              end
              default: ;
            endcase
          end
        end
        tsb_pkg::TSB_BIT: begin
          if (tick) begin
            case (q_q)
              2'h1: scl_pull_q <= 1'b0;
              2'h2: shift_q <= {shift_q[6:0], f_q[0]};
              2'h3: begin
                scl_pull_q <= 1'b1;
                if (bit_q == 3'h0) begin
                  state_q <= tsb_pkg::TSB_ACK;
                  sda_pull_q <= read_q && ack_q;
                end else begin
                  bit_q <= bit_q - 3'h1;
                  sda_pull_q <= !shift_q[7];
                end
              end
              default: ;
            endcase
          end
        end
        tsb_pkg::TSB_ACK: begin
          if (tick) begin
            case (q_q)
              2'h1: scl_pull_q <= 1'b0;
              2'h2: rsp_nack_q <= f_q[0];
              2'h3: begin
                scl_pull_q <= 1'b1;
                rsp_rdata_q <= shift_q;
                if (stop_q) begin
                  sda_pull_q <= 1'b1;
                  state_q <= tsb_pkg::TSB_STOP;
                end else begin
                  sda_pull_q <= 1'b0;
                  rsp_valid_q <= 1'b1;
                  state_q <= tsb_pkg::TSB_IDLE;
                end
              end
              default: ;
            endcase
          end
        end
        tsb_pkg::TSB_STOP: begin
          if (tick) begin
            case (q_q)
              2'h1: scl_pull_q <= 1'b0;
              2'h2: sda_pull_q <= 1'b0;
              2'h3: begin
                open_q <= 1'b0;
                rsp_valid_q <= 1'b1;
                state_q <= tsb_pkg::TSB_IDLE;
              end
              default: ;
            endcase
          end
        end
        default: state_q <= tsb_pkg::TSB_IDLE;
      endcase
    end
  end

  // Pins only ever pull low; the output value stays zero.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = scl_pull_q;
  assign sda_oe = sda_pull_q;
  assign bus_en = en_q;
  assign clk_dir = dir_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rsp_rdata_q;
  assign rsp_nack = rsp_nack_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  pull_only_a: assert property (!scl_o && !sda_o &&
    (sda_oe == sda_pull_q)) else $error("bus pin driven high");
  enable_idle_a: assert property ($fell(bus_en) |-> $past(bus_idle))
    else $error("enable dropped on busy bus");
  startup_hold_a: assert property (bus_en |-> done_q)
    else $error("enable before start-up delay");
  dir_idle_a: assert property ($changed(clk_dir) |-> $past(bus_idle))
    else $error("direction changed on busy bus");
  master_side_a: assert property
    (state_q != tsb_pkg::TSB_IDLE |-> !clk_dir)
    else $error("transfer with reversed clock");
  clock_fixed_a: assert property ($changed(scl_oe) |-> $past(tick))
    else $error("clock edge off the divider");
  data_setup_a: assert property
    ((state_q == tsb_pkg::TSB_BIT) && $changed(sda_oe) |-> scl_oe)
    else $error("data moved while clock high");

endmodule : tsb_host

// ===== rtl/tsb_pkg.sv
// Purpose: Shared constants and types for the segment buffer host controller.
// Assumes: 40 MHz system clock; 100 kHz bus clocking built from quarters.
// Notes: All timing counts derive from times given in nanoseconds.
package tsb_pkg;

  localparam int CLK_NS = 25;
  // Quarter of one bus clock period at 100 kHz.
  localparam int QUARTER_NS = 2500;
  localparam int QUARTER_CYC = QUARTER_NS / CLK_NS;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] QUARTER_LAST = CNT_W'(QUARTER_CYC - 1);
  // Time that the segments stay isolated after reset.
  localparam int STARTUP_NS = 1000000;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_FIRST = 3'h7;
  localparam logic [1:0] PINS_RST = 2'h3;

  typedef enum logic [2:0] {
    TSB_IDLE,
    TSB_START,
    TSB_BIT,
    TSB_ACK,
    TSB_STOP
  } tsb_state_t;

endpackage : tsb_pkg

// ===== verif/tsb_buf_model.sv
// Purpose: Behavioural segment buffer with a small acking slave behind it.
// Assumes: Lines are pulled up; every party only pulls low.
// Notes: The slave never holds the clock low.
`timescale 1ns/1ps
module tsb_buf_model (
  input wire logic en,
  input wire logic dir,
  input wire logic m_scl_pd,
  input wire logic m_sda_pd,
  input wire logic ack_en,
  output logic scl_m,
  output logic sda_m,
  output logic scl_s,
  output logic sda_s,
  output logic [7:0] rx
);
  logic [1:0] lock = 2'h0;
  logic [3:0] cnt = 4'h0;
  logic s_pd = 1'b0;
  initial rx = 8'h00;
  // Lines are sensed as clean logic levels.
  always @* begin
    if (!en)
      lock = 2'h0;
    else if (lock == 2'h0)
      lock = m_sda_pd ? 2'h1 : (s_pd ? 2'h2 : 2'h0);
    else if (lock == 2'h1 && !m_sda_pd)
      lock = s_pd ? 2'h2 : 2'h0;
    else if (lock == 2'h2 && !s_pd)
      lock = m_sda_pd ? 2'h1 : 2'h0;
  end
  assign scl_s = !(en && !dir && m_scl_pd);
  assign scl_m = !(m_scl_pd || (en && dir && !scl_s));
  assign sda_s = !(s_pd || (en && lock == 2'h1));
  assign sda_m = !(m_sda_pd || (en && lock == 2'h2));
  always @(negedge sda_s) if (scl_s) cnt <= 4'h0;
  always @(posedge scl_s) begin
    if (cnt < 4'h8) rx <= {rx[6:0], sda_s};
    if (cnt < 4'h9) cnt <= cnt + 4'h1;
  end
  always @(negedge scl_s) s_pd <= ack_en && cnt == 4'h8;
endmodule : tsb_buf_model

// ===== verif/tsb_host_bench.sv
// Purpose: Self-checking bench for the segment buffer host.
// Assumes: Start-up count shortened to 20 cycles.
// Notes: Inputs change on the falling clock edge.
`timescale 1ns/1ps
module tsb_host_bench;
  logic clk = 1'b0, rst = 1'b1, en_req = 1'b1, dir_req = 1'b0;
  logic cmd_valid = 1'b0, cmd_start = 1'b1, cmd_stop = 1'b1;
  logic cmd_read = 1'b0, cmd_ack = 1'b0, ack_en = 1'b1;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_ready, rsp_valid, rsp_nack, bus_idle, bus_en, clk_dir;
  logic scl_m, sda_m, scl_s, sda_s, scl_o, scl_oe, sda_o, sda_oe;
  logic [7:0] rsp_rdata, rx;
  int n_mismatch = 0, check_count = 0, n;
  always #12.5 clk = ~clk;
  tsb_host #(.STARTUP_CYC(20)) uut (.clk(clk), .rst(rst), .en_req(en_req),
    .dir_req(dir_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_ack(cmd_ack), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack), .bus_idle(bus_idle),
    .bus_en(bus_en), .clk_dir(clk_dir), .scl_i(scl_m), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda_m), .sda_o(sda_o), .sda_oe(sda_oe));
  // Masters sit on the master side only.
  tsb_buf_model model (.en(bus_en), .dir(clk_dir),
    .m_scl_pd(scl_oe && !scl_o), .m_sda_pd(sda_oe && !sda_o),
    .ack_en(ack_en), .scl_m(scl_m), .sda_m(sda_m), .scl_s(scl_s),
    .sda_s(sda_s), .rx(rx));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic xfer(input logic [7:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_wdata = d;
    n = 0;
    // Ready is looked at while valid stands, before the edge that takes it.
    while (!cmd_ready && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) n_mismatch++;
    @(posedge clk);
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (!rsp_valid && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6000) n_mismatch++;
  endtask : xfer
  task automatic t_reset;
    repeat (6) @(negedge clk);
    chk("rst_pins", 8'h00, {3'h0, bus_en, clk_dir, scl_oe, sda_oe, cmd_ready});
    rst = 1'b0;
    repeat (5) @(negedge clk);
    chk("startup_iso", 8'h00, {7'h00, bus_en});
    repeat (30) @(negedge clk);
    chk("startup_on", 8'h01, {7'h00, bus_en});
  endtask : t_reset
  task automatic t_write;
    for (int i = 0; i < 2; i++) begin
      xfer(i == 0 ? 8'ha5 : 8'h01);
      chk("latency", 8'h01, {7'h00, n == 4400 || n == 4401});
      chk("slave_rx", cmd_wdata, rx);
      chk("ack", 8'h00, {7'h00, rsp_nack});
    end
  endtask : t_write
  task automatic t_nack_disable;
    ack_en = 1'b0;
    fork
      xfer(8'h3c);
      begin
        repeat (500) @(negedge clk);
        en_req = 1'b0;
        repeat (100) @(negedge clk);
        chk("en_busy", 8'h01, {7'h00, bus_en});
      end
    join
    chk("nack", 8'h01, {7'h00, rsp_nack});
    repeat (10) @(negedge clk);
    chk("en_idle", 8'h00, {7'h00, bus_en});
    en_req = 1'b1;
    repeat (10) @(negedge clk);
    chk("en_back", 8'h01, {7'h00, bus_en});
  endtask : t_nack_disable
  task automatic t_dir;
    dir_req = 1'b1;
    repeat (10) @(negedge clk);
    chk("dir_rev", 8'h02, {6'h00, clk_dir, cmd_ready});
    dir_req = 1'b0;
    repeat (10) @(negedge clk);
    chk("dir_fwd", 8'h01, {6'h00, clk_dir, cmd_ready});
  endtask : t_dir
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  initial begin
    #(25 * 30000);
    n_mismatch++;
    summarize();
  end
  initial begin
    t_reset();
    t_write();
    t_nack_disable();
    t_dir();
    summarize();
  end
endmodule : tsb_host_bench
